/* dv/cpu_core_model.sv */
// processor core model issuing register and memory requests
`default_nettype none
module cpu_core_model (
    input  wire logic                         clock,
    output var access_control_pkg::cpu_mode_t mode,
    output var access_control_pkg::reg_req_t  reg_req,
    input  wire access_control_pkg::reg_rsp_t reg_rsp,
    output var access_control_pkg::mem_req_t  mem_req,
    input  wire access_control_pkg::mem_rsp_t mem_rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    // quiet bus until the first request
    initial begin
        mode    = access_control_pkg::mode_privileged;
        reg_req = '0;
        mem_req = '0;
    end
    // caller enters on a falling edge; answer is read one cycle later
    task automatic issue(input access_control_pkg::cpu_mode_t m,
                         input access_control_pkg::reg_req_t  r,
                         input access_control_pkg::mem_req_t  q,
                         output access_control_pkg::reg_rsp_t rr,
                         output access_control_pkg::mem_rsp_t mr);
        mode    = m;
        reg_req = r;
        mem_req = q;
        @(negedge clock);
        rr = reg_rsp;
        mr = mem_rsp;
    endtask : issue
    // released lines flip so a stale value is never mistaken for data
    task automatic idle();
        reg_req.valid = 1'b0;
        reg_req.addr  = ~reg_req.addr;
        reg_req.wdata = ~reg_req.wdata;
        mem_req.valid = 1'b0;
        mem_req.addr  = ~mem_req.addr;
    endtask : idle
endmodule : cpu_core_model
`default_nettype wire

/* dv/mode_based_register_access_control_tb_top.sv */
// self-checking bench for the mode-based access checker
`default_nettype none
module mode_based_register_access_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                          clock;     // 40 MHz
    logic                          rst_n;     // synchronous reset
    access_control_pkg::cpu_mode_t mode;      // core mode
    access_control_pkg::reg_req_t  reg_req;   // register request
    access_control_pkg::reg_rsp_t  reg_rsp;   // register answer
    access_control_pkg::mem_req_t  mem_req;   // memory request
    access_control_pkg::mem_rsp_t  mem_rsp;   // memory answer
    logic [15:0]                   seg_ptr;   // table base
    int                            err_count; // mismatches
    int                            checked;   // comparisons
    int                            m_ptr, m_pg, m_fg, m_se; // reference
    access_control_pkg::reg_rsp_t  exp_q[$]; // expected answers in order

    mode_based_register_access_control u_mode_based_register_access_control (
        .clock(clock), .rst_n(rst_n), .mode(mode), .reg_req(reg_req),
        .reg_rsp(reg_rsp), .mem_req(mem_req), .mem_rsp(mem_rsp),
        .seg_ptr(seg_ptr));
    cpu_core_model u_cpu_core_model (
        .clock(clock), .mode(mode), .reg_req(reg_req), .reg_rsp(reg_rsp),
        .mem_req(mem_req), .mem_rsp(mem_rsp));

    // free-running clock, 25 ns period
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // reference register decision; firmware uses its own grant byte
    function automatic bit reg_ok(access_control_pkg::cpu_mode_t m, int a);
        bit priv;
        priv = (m == access_control_pkg::mode_privileged);
        if (a <= 'h3f) return 1'b1;
        if (a >= 'h40 && a <= 'h4f) return priv;
        if (a >= 'h80 && a <= 'h87 && !priv)
            return (m == access_control_pkg::mode_unprivileged) ?
                   m_pg[a%8] : m_fg[a%8];
        if (a >= 'h80 && a <= 'hbf) return priv;
        return 1'b0;
    endfunction : reg_ok
    // readable contents of the mmu page; all else reads zero
    function automatic int rd_val(int a);
        case (a)
            'h40: return m_ptr >> 8;
            'h41: return m_ptr % 256;
            'h42: return m_pg;
            'h43: return m_fg;
            'h44: return m_se;
            default: return 0;
        endcase
    endfunction : rd_val
    // one compare task per kind of result
    task automatic cmp_reg(input access_control_pkg::reg_rsp_t e,
                           input access_control_pkg::reg_rsp_t g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] reg_rsp expected %h seen %h", e, g);
        end
    endtask : cmp_reg
    task automatic cmp_mem(input access_control_pkg::mem_rsp_t e,
                           input access_control_pkg::mem_rsp_t g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] mem_rsp expected %h seen %h", e, g);
        end
    endtask : cmp_mem
    task automatic cmp_ptr(input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] seg_ptr expected %h seen %h", e, g);
        end
    endtask : cmp_ptr
    // random access biased onto the mmu page so grants really change
    task automatic step();
        access_control_pkg::cpu_mode_t m;
        access_control_pkg::reg_req_t  r;
        access_control_pkg::mem_req_t  q;
        access_control_pkg::reg_rsp_t  rr;
        access_control_pkg::mem_rsp_t  mr;
        bit                            g;
        bit                            mg;
        int                            a;
        m = access_control_pkg::cpu_mode_t'($urandom % 3);
        a = ($urandom % 2) ? 'h40 + $urandom % 8 :
            ($urandom % 2) ? 'h80 + $urandom % 8 : $urandom % 256;
        r = '{1'b1, 1'($urandom), 8'(a), 8'($urandom)};
        q = '{1'b1, 1'($urandom), 16'($urandom)};
        // decision uses the state before this request's own write
        g = reg_ok(m, a);
        exp_q.push_back({1'b1, g, (g && !r.write) ? 8'(rd_val(a)) : 8'h00});
        u_cpu_core_model.issue(m, r, q, rr, mr);
        mg = (m == access_control_pkg::mode_firmware) ? 1'b1 :
             (q.addr >= 16'hc000) ? 1'b0 : m_se[q.addr >> 13];
        cmp_reg(exp_q.pop_front(), rr);
        cmp_mem('{1'b1, mg}, mr);
        if (g && r.write) begin
            case (a)
                'h40: m_ptr = (m_ptr % 256) + r.wdata * 256;
                'h41: m_ptr = (m_ptr / 256) * 256 + r.wdata;
                'h42: m_pg = r.wdata;
                'h43: m_fg = r.wdata;
                'h44: m_se = r.wdata;
                default: ;
            endcase
        end
        cmp_ptr(16'(m_ptr), seg_ptr);
    endtask : step
    // verdict and end of run, shared with the watchdog
    task automatic end_of_test();
        if (err_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test
    // run is about 825 cycles; cut it off well past that
    initial begin
        #(25 * 2000);
        err_count++;
        end_of_test();
    end
    // start-up reset, traffic, then a second reset in mid-run
    initial begin
        err_count = 0;
        checked = 0;
        rst_n = 1'b0;
        void'($urandom(32'h0e6f));
        for (int p = 0; p < 2; p++) begin
            rst_n = 1'b0;
            repeat (p ? 2 : 20) @(negedge clock);
            cmp_reg('0, reg_rsp);
            {m_ptr, m_pg, m_fg, m_se} = '0;
            rst_n = 1'b1;
            cmp_ptr(16'h0000, seg_ptr);
            repeat (400) step();
            u_cpu_core_model.idle();
            @(negedge clock);
        end
        end_of_test();
    end
endmodule : mode_based_register_access_control_tb_top
`default_nettype wire

/* rtl/access_control_defines.svh */
// constants for the mode-based register and memory access checker
`ifndef ACCESS_CONTROL_DEFINES_SVH
`define ACCESS_CONTROL_DEFINES_SVH
// register address map (8-bit register space)
`define REG_ADDR_W        8
`define REG_DATA_W        8
`define CORE_REG_LO       8'h00
`define CORE_REG_HI       8'h3f
`define MMU_REG_LO        8'h40
`define MMU_REG_HI        8'h4f
`define SEG_PTR_REG       8'h40
`define SEG_PTR_LO_REG    8'h41
`define PERIPH_GRANT_REG  8'h42
`define FW_GRANT_REG      8'h43
`define SEG_EN_REG        8'h44
`define PERIPH_REG_LO     8'h80
`define PERIPH_REG_HI     8'h87
`define HW_REG_LO         8'h80
`define HW_REG_HI         8'hbf
// reset values
`define SEG_PTR_RESET     16'h0000
`define GRANT_RESET       8'h00
`define SEG_EN_RESET      8'h00
`define READ_DENY_VALUE   8'h00
// fixed firmware partition: memory at or above this address is firmware
`define FW_PART_BASE      16'hc000
`define SEG_SHIFT         13
`endif

/* rtl/access_control_pkg.sv */
// types for the mode-based access checker
`default_nettype none
package access_control_pkg;
    typedef enum logic [1:0] {
        mode_privileged,
        mode_unprivileged,
        mode_firmware
    } cpu_mode_t;

    typedef struct packed {
        logic       valid;  // request present this cycle
        logic       write;  // 1 write, 0 read
        logic [7:0] addr;   // register address
        logic [7:0] wdata;  // write data
    } reg_req_t;

    typedef struct packed {
        logic       valid;  // answer present
        logic       grant;  // access allowed
        logic [7:0] rdata;  // read data, zero when denied
    } reg_rsp_t;

    typedef struct packed {
        logic        valid; // memory request present
        logic        write; // 1 write
        logic [15:0] addr;  // memory address
    } mem_req_t;

    typedef struct packed {
        logic valid;        // answer present
        logic grant;        // access allowed
    } mem_rsp_t;
endpackage : access_control_pkg
`default_nettype wire

/* rtl/mode_based_register_access_control.sv */
// mode-based access checker for special function registers and memory
// Contract
// (R1) mmu config registers privileged mode only
// (R2) unprivileged sees only core registers by default
// (R3) peripheral registers open when grant allows
// (R4) privileged may reach hardware component registers
// (R5) segment pointer written only in privileged mode
// (R6) reset disables every memory segment; firmware mode still reaches all memory whatever seg_en holds
// (R7) firmware partition fixed, no register alters it
// (R8) reset loads defined values and permissions
// (R9) only grant registers change access attributes
// (R10) software edits segment attributes when privileged
// (R11) denied access leaves register, reads zero
`include "access_control_defines.svh"
`default_nettype none
module mode_based_register_access_control #(
    parameter int NUM_PERIPH = 8         // peripheral registers with grants
) (
    input  wire logic                          clock,
    input  wire logic                          rst_n,
    input  wire access_control_pkg::cpu_mode_t mode,     // current cpu mode
    input  wire access_control_pkg::reg_req_t  reg_req,  // register request
    output var  access_control_pkg::reg_rsp_t  reg_rsp,  // register answer
    input  wire access_control_pkg::mem_req_t  mem_req,  // memory request
    output var  access_control_pkg::mem_rsp_t  mem_rsp,  // memory answer
    output logic [15:0]                        seg_ptr   // segment table base
);
    // attributes held by the checker itself
    logic [15:0] next_seg_ptr;
    logic [7:0]  periph_grant;           // unprivileged grants per register
    logic [7:0]  next_periph_grant;
    logic [7:0]  fw_grant;               // firmware mode grants
    logic [7:0]  next_fw_grant;
    logic [7:0]  seg_en;                 // one enable per 8 KiB segment
    logic [7:0]  next_seg_en;
    access_control_pkg::reg_rsp_t next_reg_rsp;
    access_control_pkg::mem_rsp_t next_mem_rsp;

    // address range test, used by the register decode and the checks below
    function automatic logic in_range(input logic [7:0] a,
                                      input logic [7:0] lo,
                                      input logic [7:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    // register access decision; attributes are hardwired apart from grants
    function automatic logic reg_allowed(
        input access_control_pkg::cpu_mode_t m,
        input logic [7:0] a,
        input logic [7:0] pg,
        input logic [7:0] fg);
        logic       core;
        logic       mmu;
        logic       hw;
        logic       per;
        logic [2:0] idx;
        idx  = a[2:0];
        core = in_range(a, `CORE_REG_LO, `CORE_REG_HI);
        mmu  = in_range(a, `MMU_REG_LO, `MMU_REG_HI);
        hw   = in_range(a, `HW_REG_LO, `HW_REG_HI);
        // slots past the grant count stay closed whatever the grant byte says
        per  = in_range(a, `PERIPH_REG_LO, `PERIPH_REG_HI) &&
               (int'(idx) < NUM_PERIPH);
        reg_allowed = 1'b0;
        unique case (m)
            access_control_pkg::mode_privileged: begin
                reg_allowed = core || mmu || hw; // R1 R4
            end
            access_control_pkg::mode_unprivileged: begin
                reg_allowed = core || (per && pg[idx]); // R2 R3
            end
            access_control_pkg::mode_firmware: begin
                reg_allowed = core || (per && fg[idx]); // R9
            end
            default: begin
                reg_allowed = 1'b0; // illegal mode code denies
            end
        endcase
    endfunction : reg_allowed

    // register read mux; no firmware partition register exists
    function automatic logic [7:0] reg_read(input logic [7:0] a,
                                            input logic [15:0] sp,
                                            input logic [7:0] pg,
                                            input logic [7:0] fg,
                                            input logic [7:0] se);
        reg_read = `READ_DENY_VALUE;
        unique case (a)
            `SEG_PTR_REG:      reg_read = sp[15:8];
            `SEG_PTR_LO_REG:   reg_read = sp[7:0];
            `PERIPH_GRANT_REG: reg_read = pg;
            `FW_GRANT_REG:     reg_read = fg;
            `SEG_EN_REG:       reg_read = se;
            default:           reg_read = `READ_DENY_VALUE;
        endcase
    endfunction : reg_read

    logic reg_ok;
    logic reg_wr;
    assign reg_ok = reg_allowed(mode, reg_req.addr, periph_grant, fw_grant);
    assign reg_wr = reg_req.valid && reg_req.write && reg_ok;

    // next attribute values; writes land only when the check passes
    always_comb begin
        next_seg_ptr      = seg_ptr;
        next_periph_grant = periph_grant;
        next_fw_grant     = fw_grant;
        next_seg_en       = seg_en;
        if (reg_wr) begin // R11
            unique case (reg_req.addr)
                `SEG_PTR_REG:      next_seg_ptr[15:8] = reg_req.wdata; // R5
                `SEG_PTR_LO_REG:   next_seg_ptr[7:0]  = reg_req.wdata; // R5
                `PERIPH_GRANT_REG: next_periph_grant  = reg_req.wdata; // R9
                `FW_GRANT_REG:     next_fw_grant      = reg_req.wdata; // R9
                `SEG_EN_REG:       next_seg_en        = reg_req.wdata; // R10
                default: begin
                    next_seg_en = seg_en; // other registers live elsewhere
                end
            endcase
        end
    end

    // attribute registers with restrictive reset values
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            seg_ptr      <= `SEG_PTR_RESET; // R8
            periph_grant <= `GRANT_RESET;   // R8
            fw_grant     <= `GRANT_RESET;   // R8
            seg_en       <= `SEG_EN_RESET;  // R6
        end else begin
            seg_ptr      <= next_seg_ptr;
            periph_grant <= next_periph_grant;
            fw_grant     <= next_fw_grant;
            seg_en       <= next_seg_en;
        end
    end

    // memory decision: firmware partition is a fixed compare, never stored
    function automatic logic mem_allowed(
        input access_control_pkg::cpu_mode_t m,
        input logic [15:0] a,
        input logic [7:0] se);
        logic fw_area;
        fw_area = (a >= `FW_PART_BASE); // R7
        mem_allowed = 1'b0;
        unique case (m)
            access_control_pkg::mode_firmware: mem_allowed = 1'b1;
            access_control_pkg::mode_privileged,
            access_control_pkg::mode_unprivileged: begin
                mem_allowed = !fw_area && se[a[15:`SEG_SHIFT]]; // R6 R7
            end
            default: mem_allowed = 1'b0;
        endcase
    endfunction : mem_allowed

    // answers one cycle after the request; denied reads give zero
    always_comb begin
        next_reg_rsp.valid = reg_req.valid;
        next_reg_rsp.grant = reg_req.valid && reg_ok;
        next_reg_rsp.rdata = `READ_DENY_VALUE;
        if (reg_req.valid && !reg_req.write && reg_ok) begin // R11
            next_reg_rsp.rdata = reg_read(reg_req.addr, seg_ptr,
                                          periph_grant, fw_grant, seg_en);
        end
        next_mem_rsp.valid = mem_req.valid;
        next_mem_rsp.grant = mem_req.valid &&
                             mem_allowed(mode, mem_req.addr, seg_en);
    end

    // answer registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reg_rsp <= '0;
            mem_rsp <= '0;
        end else begin
            reg_rsp <= next_reg_rsp;
            mem_rsp <= next_mem_rsp;
        end
    end

    // checks beside the logic
    mmu_priv_only_a: assert property ( // R1
        @(posedge clock) disable iff (!rst_n)
        reg_req.valid && in_range(reg_req.addr, `MMU_REG_LO, `MMU_REG_HI) &&
        mode != access_control_pkg::mode_privileged |=> !reg_rsp.grant)
        else $error("mmu register reached outside privileged mode");
    core_open_a: assert property ( // R2
        @(posedge clock) disable iff (!rst_n)
        reg_req.valid && in_range(reg_req.addr, `CORE_REG_LO, `CORE_REG_HI)
        |=> reg_rsp.grant)
        else $error("core register denied");
    periph_grant_a: assert property ( // R3
        @(posedge clock) disable iff (!rst_n)
        reg_req.valid && mode == access_control_pkg::mode_unprivileged &&
        in_range(reg_req.addr, `PERIPH_REG_LO, `PERIPH_REG_HI)
        |=> reg_rsp.grant == $past(periph_grant[reg_req.addr[2:0]]))
        else $error("peripheral grant not followed");
    hw_priv_a: assert property ( // R4
        @(posedge clock) disable iff (!rst_n)
        reg_req.valid && mode == access_control_pkg::mode_privileged &&
        in_range(reg_req.addr, `HW_REG_LO, `HW_REG_HI) |=> reg_rsp.grant)
        else $error("hardware register denied in privileged mode");
    seg_ptr_hold_a: assert property ( // R5
        @(posedge clock) disable iff (!rst_n)
        mode != access_control_pkg::mode_privileged |=> $stable(seg_ptr))
        else $error("segment pointer changed outside privileged mode");
    // no disable here: this one watches the reset itself
    seg_reset_a: assert property ( // R6 R8
        @(posedge clock)
        !rst_n |=> seg_en == `SEG_EN_RESET && periph_grant == `GRANT_RESET &&
        fw_grant == `GRANT_RESET && seg_ptr == `SEG_PTR_RESET &&
        !reg_rsp.valid && !mem_rsp.valid)
        else $error("reset values not loaded");
    fw_part_a: assert property ( // R7
        @(posedge clock) disable iff (!rst_n)
        mem_req.valid && mem_req.addr >= `FW_PART_BASE &&
        mode != access_control_pkg::mode_firmware |=> !mem_rsp.grant)
        else $error("firmware partition reached");
    deny_read_a: assert property ( // R11
        @(posedge clock) disable iff (!rst_n)
        reg_req.valid && !reg_ok |=> reg_rsp.valid && !reg_rsp.grant &&
        reg_rsp.rdata == `READ_DENY_VALUE)
        else $error("denied read leaked data");
    grant_hold_a: assert property ( // R9
        @(posedge clock) disable iff (!rst_n)
        !reg_wr |=> $stable(periph_grant) && $stable(fw_grant))
        else $error("grant changed without allowed write");

    // covers for the main scenarios
    cov_priv_wr_c: cover property (@(posedge clock) reg_wr &&
        reg_req.addr == `SEG_PTR_REG);
    cov_deny_c: cover property (@(posedge clock) reg_rsp.valid &&
        !reg_rsp.grant);
    cov_unpriv_grant_c: cover property (@(posedge clock) reg_rsp.grant &&
        mode == access_control_pkg::mode_unprivileged);
    cov_mem_ok_c: cover property (@(posedge clock) mem_rsp.grant);
endmodule : mode_based_register_access_control
`default_nettype wire
